//--- common/sar_adc_seq_map.svh
`ifndef SAR_ADC_SEQ_MAP_SVH
`define SAR_ADC_SEQ_MAP_SVH

// ==========================================
// register addresses
`define ADDR_CONV_CONFIG 16'hf000
`define ADDR_SAMPLE_MODE 16'hf001
`define ADDR_SEQ_LOW 16'hf002
`define ADDR_SEQ_HIGH 16'hf003
`define ADDR_EVT_LOW 16'hf004
`define ADDR_EVT_HIGH 16'hf005
`define ADDR_UNIT_ENABLE 16'hf007
`define ADDR_CNT_CLEAR 16'hf008
`define ADDR_THR_LOW 16'hf009
`define ADDR_THR_HIGH 16'hf00a
`define ADDR_SKIP_COUNT 16'hf00b

// ==========================================
// field positions
`define CFG_THR_EN_BIT 7
`define CFG_MODE_BIT 6
`define CFG_SPEED_BIT 5
`define CFG_TRIG_MSB 4
`define DSH_MODE_BIT 7
`define ENABLE_BIT 0
`define CLR_CPU_BIT 7
`define CLR_XFER_BIT 6

// ==========================================
// reset values and codes
`define REG_RESET 8'h00
`define SKIP_CLEAR_VALUE 8'h00
`define TRIG_CODE_CPU 5'h00
`define TRIG_CODE_GPIO_FIRST 5'h01
`define TRIG_CODE_CMP_FIRST 5'h0d
`define TRIG_CODE_TMR_FIRST 5'h11
`define TRIG_CODE_PWM_FIRST 5'h15
`define TRIG_CODE_LAST 5'h1c
`define NUM_CHANNELS 10
`define CH0_PARTNER_A 4'h1
`define CH0_PARTNER_B 4'h4
`define CH0_PARTNER_C 4'h5

`endif

//--- common/sar_adc_seq_pkg.sv
package sar_adc_seq_pkg;

    // ==========================================
    // sequencer states, gray along ST_IDLE, ST_START, ST_WAIT, ST_FINISH and back to ST_IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b11,
        ST_FINISH = 2'b10
    } seq_state_t;

    // ==========================================
    // trigger sources
    typedef struct packed {
        logic [3:0] gpio_rise;
        logic [3:0] gpio_fall;
        logic [3:0] cmp_pulse;
        logic [3:0] tmr_match;
        logic [7:0] pwm_event;
    } trig_src_t;

    // ==========================================
    // request toward the converter core
    typedef struct packed {
        logic start;
        logic [3:0] channel;
        logic fast;
        logic dual;
        logic [3:0] partner;
    } conv_req_t;

endpackage

//--- core/sar_adc_next_channel.sv
`timescale 1ns/1ps
`default_nettype none

module sar_adc_next_channel
    import sar_adc_seq_pkg::*;
#(
    parameter int NCH = 10
) (
    input wire logic [NCH-1:0] mask_i,
    input wire logic [3:0] cur_i,
    output logic [3:0] first_o,
    output logic [3:0] next_o,
    output logic last_o
);

    // ==========================================
    // channels above current
    logic [NCH-1:0] above;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_above
            assign above[g] = mask_i[g] && (4'(g) > cur_i);
        end
    endgenerate

    // ==========================================
    // lowest selected picks
    logic [3:0] first_c;
    logic [3:0] up_c;
    logic up_found;

    always_comb begin
        first_c = 4'h0;
        up_c = 4'h0;
        up_found = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (mask_i[i]) begin
                first_c = 4'(i);
            end
            if (above[i]) begin
                up_c = 4'(i);
                up_found = 1'b1;
            end
        end
    end

    // ascending, wrapping
    assign first_o = first_c;
    assign next_o = up_found ? up_c : first_c;
    assign last_o = !up_found;

endmodule

`default_nettype wire

//--- core/sar_adc_sequencer_control.sv
// Summary of operation
// - cfg bit 7 enables ch0 threshold; bit 5 selects fast conversion
// - cfg bit 6: burst per trigger, or one step per trigger
// - trigger 0 is cpu start; 1..12 gpio fall/rise/both edges
// - 13..16 comparators, 17..20 timer matches, 21..28 pwm events
// - sample-mode bit 7 selects dual sample-hold
// - reserved bits read zero and are written zero
// - selected channels convert ascending, cyclically
// - ch0 pairs with ch1, else ch4, else ch5
// - per-channel bits route completion to the event output
// - enable bit 0 activates the unit; not cleared mid-conversion (a write of 0 takes effect at once and idles the sequencer)
// - write 1 to bit 7 or 6 clears cpu or transfer counters
// - 8-bit count of skipped ch0 results; write 0x00 clears it
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_seq_map.svh"

module sar_adc_sequencer_control
    import sar_adc_seq_pkg::*;
#(
    parameter int NCH = `NUM_CHANNELS
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    output logic [7:0] bus_rdata_o,
    input wire logic cpu_start_i,
    input wire trig_src_t trig_i,
    output conv_req_t conv_req_o,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output logic busy_o,
    output logic irq_o,
    output logic event_o,
    output logic ch0_update_o,
    output logic clear_cpu_read_count_o,
    output logic clear_transfer_read_count_o,
    output logic unit_enable_o
);

    // ==========================================
    // register file
    logic [7:0] cfg_q;
    logic dual_sample_hold_mode_q;
    logic [NCH-1:0] channel_sequence_bit_q;
    logic [NCH-1:0] channel_event_select_q;
    logic enable_q;
    logic [9:0] ch0_update_threshold_q;
    logic [7:0] ch0_skip_count_q;
    logic [7:0] rdata_q;
    logic clr_cpu_q;
    logic clr_xfer_q;

    logic wr_cfg, wr_dsh, wr_sl, wr_sh, wr_el, wr_eh, wr_en, wr_clr;
    logic wr_tl, wr_th, wr_skip;

    always_comb begin
        wr_cfg = bus_wr_i && (bus_addr_i == `ADDR_CONV_CONFIG);
        wr_dsh = bus_wr_i && (bus_addr_i == `ADDR_SAMPLE_MODE);
        wr_sl = bus_wr_i && (bus_addr_i == `ADDR_SEQ_LOW);
        wr_sh = bus_wr_i && (bus_addr_i == `ADDR_SEQ_HIGH);
        wr_el = bus_wr_i && (bus_addr_i == `ADDR_EVT_LOW);
        wr_eh = bus_wr_i && (bus_addr_i == `ADDR_EVT_HIGH);
        wr_en = bus_wr_i && (bus_addr_i == `ADDR_UNIT_ENABLE);
        wr_clr = bus_wr_i && (bus_addr_i == `ADDR_CNT_CLEAR);
        wr_tl = bus_wr_i && (bus_addr_i == `ADDR_THR_LOW);
        wr_th = bus_wr_i && (bus_addr_i == `ADDR_THR_HIGH);
        wr_skip = bus_wr_i && (bus_addr_i == `ADDR_SKIP_COUNT);
    end

    // config register
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q <= `REG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= bus_wdata_i;
        end
    end

    // bit 7 only
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dual_sample_hold_mode_q <= 1'b0;
        end else if (wr_dsh) begin
            dual_sample_hold_mode_q <= bus_wdata_i[`DSH_MODE_BIT];
        end
    end

    // sequence and event masks
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            channel_sequence_bit_q <= '0;
        end else if (wr_sl) begin
            channel_sequence_bit_q[7:0] <= bus_wdata_i;
        end else if (wr_sh) begin
            channel_sequence_bit_q[NCH-1:8] <= bus_wdata_i[NCH-9:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            channel_event_select_q <= '0;
        end else if (wr_el) begin
            channel_event_select_q[7:0] <= bus_wdata_i;
        end else if (wr_eh) begin
            channel_event_select_q[NCH-1:8] <= bus_wdata_i[NCH-9:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable_q <= 1'b0;
        end else if (wr_en) begin
            enable_q <= bus_wdata_i[`ENABLE_BIT];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch0_update_threshold_q <= '0;
        end else if (wr_tl) begin
            ch0_update_threshold_q[7:0] <= bus_wdata_i;
        end else if (wr_th) begin
            ch0_update_threshold_q[9:8] <= bus_wdata_i[1:0];
        end
    end

    // one-cycle counter clears
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clr_cpu_q <= 1'b0;
            clr_xfer_q <= 1'b0;
        end else begin
            clr_cpu_q <= wr_clr && bus_wdata_i[`CLR_CPU_BIT];
            clr_xfer_q <= wr_clr && bus_wdata_i[`CLR_XFER_BIT];
        end
    end

    // ==========================================
    // trigger selection
    logic [28:0] all_evt;
    logic trig_hit;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_gpio
            assign all_evt[3*g+1] = trig_i.gpio_fall[g];
            assign all_evt[3*g+2] = trig_i.gpio_rise[g];
            assign all_evt[3*g+3] = trig_i.gpio_fall[g] | trig_i.gpio_rise[g];
        end
    endgenerate

    assign all_evt[0] = cpu_start_i;
    assign all_evt[16:13] = trig_i.cmp_pulse;
    assign all_evt[20:17] = trig_i.tmr_match;
    assign all_evt[28:21] = trig_i.pwm_event;

    logic [4:0] trig_code;
    assign trig_code = cfg_q[`CFG_TRIG_MSB:0];

    always_comb begin
        if (trig_code <= `TRIG_CODE_LAST) begin
            trig_hit = all_evt[trig_code];
        end else begin
            trig_hit = 1'b0;
        end
    end

    // ==========================================
    // channel walk
    logic [3:0] ptr_q;
    logic [3:0] next_ch;
    logic last_ch;
    logic seq_empty;

    sar_adc_next_channel #(
        .NCH(NCH)
    ) u_next (
        .mask_i(channel_sequence_bit_q),
        .cur_i(ptr_q),
        .first_o(),
        .next_o(next_ch),
        .last_o(last_ch)
    );

    assign seq_empty = (channel_sequence_bit_q == '0);

    // ch0 partner choice
    logic has_partner;
    logic [3:0] partner;

    always_comb begin
        has_partner = 1'b1;
        partner = `CH0_PARTNER_A;
        if (channel_sequence_bit_q[1]) begin
            partner = `CH0_PARTNER_A;
        end else if (channel_sequence_bit_q[4]) begin
            partner = `CH0_PARTNER_B;
        end else if (channel_sequence_bit_q[5]) begin
            partner = `CH0_PARTNER_C;
        end else begin
            has_partner = 1'b0;
            partner = 4'h0;
        end
    end

    // ==========================================
    // sequencer
    seq_state_t state_q;
    logic [3:0] cur_ch_q;
    logic cur_last_q;
    logic start_q;
    logic dual_q;
    logic [3:0] partner_q;
    logic step_mode;
    logic go;

    assign step_mode = cfg_q[`CFG_MODE_BIT];
    assign go = enable_q && !seq_empty && trig_hit;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
        end else if (!enable_q) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (conv_done_i) begin
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    if (!step_mode && !cur_last_q) begin
                        state_q <= ST_START;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pointer walks ascending and wraps
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_q <= 4'h0;
            cur_ch_q <= 4'h0;
            cur_last_q <= 1'b0;
        end else if (!enable_q) begin
            ptr_q <= 4'h0;
        end else if (state_q == ST_IDLE && go) begin
            cur_ch_q <= channel_sequence_bit_q[ptr_q] ? ptr_q : next_ch;
        end else if (state_q == ST_FINISH) begin
            cur_ch_q <= ptr_q;
        end else if (state_q == ST_START) begin
            ptr_q <= cur_ch_q;
        end else if (state_q == ST_WAIT && conv_done_i) begin
            ptr_q <= next_ch;
            cur_last_q <= last_ch;
        end
    end

    // core request, registered
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_q <= 1'b0;
            dual_q <= 1'b0;
            partner_q <= 4'h0;
        end else begin
            start_q <= (state_q == ST_START);
            dual_q <= (state_q == ST_START) && (cur_ch_q == 4'h0) && has_partner
                      && dual_sample_hold_mode_q;
            partner_q <= partner;
        end
    end

    // ==========================================
    // completion: irq, event, ch0 threshold
    logic irq_q;
    logic event_q;
    logic ch0_upd_q;
    logic [9:0] ch0_last_q;
    logic done_now;
    logic ch0_skip;
    logic [9:0] diff;

    assign done_now = (state_q == ST_WAIT) && conv_done_i;
    assign diff = (conv_data_i >= ch0_last_q) ? (conv_data_i - ch0_last_q)
                                              : (ch0_last_q - conv_data_i);
    assign ch0_skip = done_now && (cur_ch_q == 4'h0) && cfg_q[`CFG_THR_EN_BIT]
                      && (diff < ch0_update_threshold_q);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            irq_q <= done_now && (step_mode || last_ch);
            event_q <= done_now && channel_event_select_q[cur_ch_q];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch0_upd_q <= 1'b0;
            ch0_last_q <= 10'h000;
        end else begin
            ch0_upd_q <= done_now && (cur_ch_q == 4'h0) && !ch0_skip;
            if (done_now && (cur_ch_q == 4'h0) && !ch0_skip) begin
                ch0_last_q <= conv_data_i;
            end
        end
    end

    // a write and an increment in the same cycle give the written value plus one
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ch0_skip_count_q <= `REG_RESET;
        end else if (ch0_skip) begin
            ch0_skip_count_q <= (wr_skip ? bus_wdata_i : ch0_skip_count_q) + 8'h01;
        end else if (wr_skip) begin
            ch0_skip_count_q <= bus_wdata_i;
        end
    end

    // ==========================================
    // read path
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= `REG_RESET;
        end else if (bus_rd_i) begin
            unique case (bus_addr_i)
                `ADDR_CONV_CONFIG: rdata_q <= cfg_q;
                `ADDR_SAMPLE_MODE: rdata_q <= {dual_sample_hold_mode_q, 7'h00};
                `ADDR_SEQ_LOW: rdata_q <= channel_sequence_bit_q[7:0];
                `ADDR_SEQ_HIGH: rdata_q <= {6'h00, channel_sequence_bit_q[NCH-1:8]};
                `ADDR_EVT_LOW: rdata_q <= channel_event_select_q[7:0];
                `ADDR_EVT_HIGH: rdata_q <= {6'h00, channel_event_select_q[NCH-1:8]};
                `ADDR_UNIT_ENABLE: rdata_q <= {7'h00, enable_q};
                `ADDR_CNT_CLEAR: rdata_q <= 8'h00;
                `ADDR_THR_LOW: rdata_q <= ch0_update_threshold_q[7:0];
                `ADDR_THR_HIGH: rdata_q <= {6'h00, ch0_update_threshold_q[9:8]};
                `ADDR_SKIP_COUNT: rdata_q <= ch0_skip_count_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // outputs
    assign bus_rdata_o = rdata_q;
    assign conv_req_o.start = start_q;
    assign conv_req_o.channel = cur_ch_q;
    assign conv_req_o.fast = cfg_q[`CFG_SPEED_BIT];
    assign conv_req_o.dual = dual_q;
    assign conv_req_o.partner = partner_q;
    assign busy_o = (state_q != ST_IDLE);
    assign irq_o = irq_q;
    assign event_o = event_q;
    assign ch0_update_o = ch0_upd_q;
    assign clear_cpu_read_count_o = clr_cpu_q;
    assign clear_transfer_read_count_o = clr_xfer_q;
    assign unit_enable_o = enable_q;

endmodule

`default_nettype wire

//--- tb/sar_adc_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_seq_map.svh"
module sar_adc_seq_chk
    import sar_adc_seq_pkg::*;
#(
    parameter int NCH = 10
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic [7:0] bus_rdata_o,
    input wire conv_req_t conv_req_o,
    input wire logic conv_done_i,
    input wire logic busy_o,
    input wire logic irq_o,
    input wire logic event_o,
    input wire logic ch0_update_o,
    input wire logic clear_cpu_read_count_o,
    input wire logic clear_transfer_read_count_o,
    input wire logic unit_enable_o
);
    // ==========================================
    // port relations
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic [7:0] zmask;
    always_comb begin
        case (bus_addr_i)
            `ADDR_SAMPLE_MODE: zmask = 8'h7f;
            `ADDR_SEQ_HIGH, `ADDR_EVT_HIGH, `ADDR_THR_HIGH: zmask = 8'hfc;
            `ADDR_UNIT_ENABLE: zmask = 8'hfe;
            `ADDR_CNT_CLEAR, 16'hf006: zmask = 8'hff;
            default: zmask = 8'h00;
        endcase
    end
    reserved_zero_a: assert property (bus_rd_i |=> (bus_rdata_o & $past(zmask)) == 8'h00)
        else $error("reserved bits set");
    rdata_hold_a: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
        else $error("rdata moved");
    enable_follow_a: assert property (bus_wr_i && bus_addr_i == `ADDR_UNIT_ENABLE
        |=> unit_enable_o == $past(bus_wdata_i[0])) else $error("enable lost");
    clear_pulse_a: assert property (bus_wr_i && bus_addr_i == `ADDR_CNT_CLEAR |=>
        clear_cpu_read_count_o == $past(bus_wdata_i[7])
        && clear_transfer_read_count_o == $past(bus_wdata_i[6])) else $error("clear pulse wrong");
    disabled_idle_a: assert property (!unit_enable_o |=> !busy_o)
        else $error("busy while disabled");
    start_follow_a: assert property ($rose(busy_o) |=> conv_req_o.start)
        else $error("no start");
    start_pulse_a: assert property (conv_req_o.start |-> busy_o ##1 !conv_req_o.start)
        else $error("start too long");
    irq_cause_a: assert property (irq_o |-> $past(conv_done_i))
        else $error("stray irq");
    event_cause_a: assert property (event_o |-> $past(conv_done_i))
        else $error("stray event");
    dual_ch0_a: assert property (conv_req_o.dual |-> conv_req_o.start
        && conv_req_o.channel == 4'h0 && conv_req_o.partner inside {4'h1, 4'h4, 4'h5})
        else $error("bad dual");
    ch0_update_a: assert property (ch0_update_o |-> $past(conv_done_i)
        && conv_req_o.channel == 4'h0) else $error("bad update");
    cover property (irq_o);
    cover property (conv_req_o.dual);
    cover property (event_o);
endmodule
bind sar_adc_sequencer_control sar_adc_seq_chk #(.NCH(NCH)) i_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
    .conv_req_o(conv_req_o), .conv_done_i(conv_done_i), .busy_o(busy_o), .irq_o(irq_o),
    .event_o(event_o), .ch0_update_o(ch0_update_o),
    .clear_cpu_read_count_o(clear_cpu_read_count_o),
    .clear_transfer_read_count_o(clear_transfer_read_count_o), .unit_enable_o(unit_enable_o));
`default_nettype wire

//--- tb/sar_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module sar_core_model
    import sar_adc_seq_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire conv_req_t req_i,
    input wire logic [7:0] lat_i,
    input wire logic [9:0] value_i,
    output logic done_o,
    output logic [9:0] data_o
);
    // ==========================================
    // conversion delay
    logic [7:0] cnt_q;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
            done_o <= 1'b0;
            data_o <= 10'h000;
        end else begin
            done_o <= 1'b0;
            data_o <= ~data_o;
            if (req_i.start) begin
                cnt_q <= lat_i;
            end else if (cnt_q == 8'h01) begin
                cnt_q <= 8'h00;
                done_o <= 1'b1;
                data_o <= value_i;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/test_sar_adc_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_seq_map.svh"
module test_sar_adc_sequencer_control
    import sar_adc_seq_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [15:0] addr = 16'hf000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cpu = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] lat = 8'h01;
    logic [9:0] value = 10'h000;
    trig_src_t trig = '0;
    conv_req_t req;
    logic [7:0] rdata, d;
    logic [9:0] cdata;
    logic done, busy, irq, evt, upd, clr_c, clr_t, en;
    logic [3:0] chq[$];
    logic [4:0] dq[$];
    int n_irq, n_evt, n_upd, n_cc, n_ct, cycles, fail_count, n_checks, k, i;
    logic [15:0] ad[12];
    logic [7:0] mk[12];
    logic [7:0] ds[5];
    logic [7:0] dm[5];
    logic [4:0] de[5];
    logic [9:0] tv[4];
    always #12.5 mclk_i = ~mclk_i;
    sar_adc_sequencer_control i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_addr_i(addr),
        .bus_wr_i(wr), .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
        .cpu_start_i(cpu), .trig_i(trig), .conv_req_o(req), .conv_done_i(done),
        .conv_data_i(cdata), .busy_o(busy), .irq_o(irq), .event_o(evt), .ch0_update_o(upd),
        .clear_cpu_read_count_o(clr_c), .clear_transfer_read_count_o(clr_t),
        .unit_enable_o(en));
    sar_core_model i_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req), .lat_i(lat),
        .value_i(value), .done_o(done), .data_o(cdata));
    // ==========================================
    // monitor and timeout
    always @(posedge mclk_i) begin
        cycles++;
        if (req.start === 1'b1) begin
            chq.push_back(req.channel);
            dq.push_back({req.dual, req.partner});
        end
        n_irq += int'(irq === 1'b1);
        n_evt += int'(evt === 1'b1);
        n_upd += int'(upd === 1'b1);
        n_cc += int'(clr_c === 1'b1);
        n_ct += int'(clr_t === 1'b1);
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ==========================================
    // tasks
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrb(logic [15:0] a, logic [7:0] v);
        @(posedge mclk_i);
        #1;
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(posedge mclk_i);
        #1;
        wr = 1'b0;
    endtask
    task automatic rdb(logic [15:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge mclk_i);
        #1;
        rd = 1'b0;
        v = rdata;
    endtask
    task automatic arm(logic [7:0] cfg, logic [4:0] tg, logic [7:0] sl, sh, el, eh, sm,
                       logic [9:0] thr);
        wrb(`ADDR_UNIT_ENABLE, 8'h00);
        wrb(`ADDR_CONV_CONFIG, cfg);
        wrb(`ADDR_SAMPLE_MODE, sm);
        wrb(`ADDR_SEQ_LOW, sl);
        wrb(`ADDR_SEQ_HIGH, sh);
        wrb(`ADDR_EVT_LOW, el);
        wrb(`ADDR_EVT_HIGH, eh);
        wrb(`ADDR_THR_LOW, thr[7:0]);
        wrb(`ADDR_THR_HIGH, {6'h00, thr[9:8]});
        wrb(`ADDR_UNIT_ENABLE, 8'h01);
        repeat (40) @(posedge mclk_i);
        wrb(`ADDR_CONV_CONFIG, cfg | {3'h0, tg});
        chq.delete();
        dq.delete();
        n_irq = 0;
        n_evt = 0;
        n_upd = 0;
    endtask
    task automatic fire(int kd, int ix);
        @(posedge mclk_i);
        #1;
        case (kd)
            0: cpu = 1'b1;
            1: trig.gpio_fall[ix] = 1'b1;
            2: trig.gpio_rise[ix] = 1'b1;
            3: trig.cmp_pulse[ix] = 1'b1;
            4: trig.tmr_match[ix] = 1'b1;
            default: trig.pwm_event[ix] = 1'b1;
        endcase
        @(posedge mclk_i);
        #1;
        cpu = 1'b0;
        trig = '0;
    endtask
    task automatic settle();
        int n;
        n = 0;
        repeat (4) @(posedge mclk_i);
        while (busy !== 1'b0 && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (2) @(posedge mclk_i);
        #1;
        chk("busy", {7'h00, busy}, 8'h00);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        ad = '{`ADDR_CONV_CONFIG, `ADDR_SAMPLE_MODE, `ADDR_SEQ_LOW, `ADDR_SEQ_HIGH,
               `ADDR_EVT_LOW, `ADDR_EVT_HIGH, `ADDR_CNT_CLEAR, `ADDR_THR_LOW, `ADDR_THR_HIGH,
               `ADDR_SKIP_COUNT, 16'hf006, `ADDR_UNIT_ENABLE};
        mk = '{8'hff, 8'h80, 8'hff, 8'h03, 8'hff, 8'h03, 8'h00, 8'hff, 8'h03, 8'hff, 8'h00, 8'h01};
        ds = '{8'h21, 8'h31, 8'h03, 8'h01, 8'h03};
        dm = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
        de = '{5'h15, 5'h14, 5'h11, 5'h00, 5'h00};
        tv = '{10'h12c, 10'h1f4, 10'h230, 10'h231};
        repeat (12) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        foreach (ad[j]) begin
            rdb(ad[j], d);
            chk("reset value", d, 8'h00);
            wrb(ad[j], 8'hff);
            rdb(ad[j], d);
            chk("read back", d, mk[j]);
        end
        $display("registers done");
        foreach (ds[j]) begin
            n_cc = 0;
            n_ct = 0;
            wrb(`ADDR_CNT_CLEAR, 8'hc0 >> j);
            repeat (3) @(posedge mclk_i);
            chk("cpu clear", 8'(n_cc), {7'h00, j == 0});
            chk("xfer clear", 8'(n_ct), {7'h00, j <= 1});
        end
        $display("clears done");
        arm(8'h20, 5'h00, 8'h3c, 8'h00, 8'h28, 8'h00, 8'h00, 10'h000);
        fire(0, 0);
        settle();
        chk("fast", {7'h00, req.fast}, 8'h01);
        chk("count", 8'(chq.size()), 8'h04);
        foreach (chq[j]) chk("channel", 8'(chq[j]), 8'(j + 2));
        chk("irq", 8'(n_irq), 8'h01);
        chk("events", 8'(n_evt), 8'h02);
        lat = 8'h09;
        arm(8'h40, 5'h02, 8'h88, 8'h02, 8'h00, 8'h02, 8'h00, 10'h000);
        repeat (4) begin
            fire(2, 0);
            settle();
        end
        chk("slow", {7'h00, req.fast}, 8'h00);
        chk("step count", 8'(chq.size()), 8'h04);
        chk("step irq", 8'(n_irq), 8'h04);
        chk("step events", 8'(n_evt), 8'h01);
        foreach (chq[j]) chk("step channel", 8'(chq[j]), j % 3 == 0 ? 8'h03 : j == 1 ? 8'h07 : 8'h09);
        $display("sequence done");
        foreach (ds[j]) begin
            arm(8'h00, 5'h00, ds[j], 8'h00, 8'h00, 8'h00, dm[j], 10'h000);
            fire(0, 0);
            settle();
            chk("dual bit", {7'h00, dq[0][4]}, {7'h00, de[j][4]});
            if (de[j][4]) chk("partner", {4'h0, dq[0][3:0]}, {4'h0, de[j][3:0]});
        end
        $display("dual done");
        for (int c = 1; c < 32; c++) begin
            k = c <= 12 ? ((c - 1) % 3 == 1 ? 2 : 1) : c <= 16 ? 3 : c <= 20 ? 4 : 5;
            i = c <= 12 ? (c - 1) / 3 : c <= 16 ? c - 13 : c <= 20 ? c - 17 : (c - 21) % 8;
            lat = c[0] ? 8'h01 : 8'h09;
            arm(8'h00, 5'(c), 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 10'h000);
            fire(k, (i + 1) % (k == 5 ? 8 : 4));
            repeat (6) @(posedge mclk_i);
            chk("other source", 8'(chq.size()), 8'h00);
            fire(k, i);
            settle();
            chk("code start", 8'(chq.size()), {7'h00, c < 29});
        end
        arm(8'h00, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 10'h000);
        fire(0, 0);
        repeat (8) @(posedge mclk_i);
        chk("empty sequence", 8'(chq.size()), 8'h00);
        $display("triggers done");
        arm(8'h80, 5'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 10'h104);
        wrb(`ADDR_SKIP_COUNT, 8'h00);
        foreach (tv[j]) begin
            value = tv[j];
            fire(0, 0);
            settle();
        end
        chk("updates", 8'(n_upd), 8'h02);
        rdb(`ADDR_SKIP_COUNT, d);
        chk("skips", d, 8'h02);
        wrb(`ADDR_SKIP_COUNT, 8'h00);
        rdb(`ADDR_SKIP_COUNT, d);
        chk("skip clear", d, 8'h00);
        $display("threshold done");
        stop_test();
    end
endmodule
`default_nettype wire
